/* File: blink_code_diag_mode_selector.sv */
// What this block does
// [R1] Press count picks mode: 1 active, 2 inactive, 3 clear, 4 config, 5 test.
// [R2] Reconfiguration needs switch held at power-up, released, then seven presses.
// [R3] Active report shows each fault as a two-digit message.
// [R4] Power cycle clears active codes except wheel speed sensor codes.
// [R5] Sensor codes clear after power cycle plus valid speed on all sensors.
// [R6] Three presses clear all active codes.
// [R7] Cleared codes and configuration changes are written into the history store.
// [R8] Two presses report every inactive code held in history.
// [R9] Tool command clears sensor codes without any wheel speed seen.
// [R10] Test mode disables traction control, survives power cycles, tool can clear.
// [R11] Three presses also end the blink code session.
// [R12] Four presses report six configuration digits in fixed order.
// [R13] First four digits encode supply, sensor count, modulator count, layout.
// [R14] Fifth digit encodes traction control: 2 none, 3 engine, 4 brake, 5 both.
// [R15] Sixth digit encodes retarder: 1 none, 2 network, 3 relay, 4 both.
// [R16] Fitted configuration reports 2-6-6-1-5-1.
// [R17] Press counts if 0.1 s to under 5 s; 5 s hold is switch fault. Presses after the first are timed from the previous release.
// [R18] Gaps over two seconds end the press sequence.
// [R19] Response starts 3.5 s after the last press.
// [R20] Blinks 0.5 s on/off, 1.5 s digit gap, 2.5 s message gap, 5 s end.
// [R21] Unlisted press counts select nothing and return to normal operation.
`timescale 1ns/1ns
module blink_code_diag_mode_selector #(
  parameter int ACT_DEPTH = 8,
  parameter int HIST_DEPTH = 16,
  parameter diag_pkg::cfg_report_t CFG_REPORT = diag_pkg::FITTED_CFG,
  parameter logic [31:0] PRESS_MIN_CYC = diag_pkg::PRESS_MIN_CYC,
  parameter logic [31:0] PRESS_MAX_CYC = diag_pkg::PRESS_MAX_CYC,
  parameter logic [31:0] GAP_MAX_CYC = diag_pkg::GAP_MAX_CYC,
  parameter logic [31:0] RESPONSE_PAUSE_CYC = diag_pkg::RESPONSE_PAUSE_CYC,
  parameter logic [31:0] BLINK_ON_CYC = diag_pkg::BLINK_ON_CYC,
  parameter logic [31:0] BLINK_OFF_CYC = diag_pkg::BLINK_OFF_CYC,
  parameter logic [31:0] DIGIT_GAP_CYC = diag_pkg::DIGIT_GAP_CYC,
  parameter logic [31:0] MSG_GAP_CYC = diag_pkg::MSG_GAP_CYC,
  parameter logic [31:0] END_ON_CYC = diag_pkg::END_ON_CYC
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic reset_in,
  // Technician switch, power and vehicle state.
  input wire logic switch_in,
  input wire logic ignition_on_in,
  input wire logic vehicle_moving_in,
  input wire logic wheel_speed_valid_in,
  // Fault and event sources.
  input wire diag_pkg::fault_t new_fault_in,
  input wire logic config_change_in,
  // External diagnostic tool commands.
  input wire logic tool_clear_in,
  input wire logic tool_test_set_in,
  input wire logic tool_test_clear_in,
  // Lamp and status.
  output logic lamp_out,
  output logic switch_fault_out,
  output logic test_mode_out,
  output logic traction_control_enable_out,
  output logic reconfig_mode_out
);
  localparam int AW = $clog2(ACT_DEPTH);
  localparam int HW = $clog2(HIST_DEPTH);

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_PRESS = 3'b001,
    S_STUCK = 3'b010,
    S_GAP = 3'b011,
    S_DIGIT = 3'b100,
    S_WAIT = 3'b101
  } state_t;

  // Lowest set bit of mask at or above from.
  function automatic logic [5:0] next_set(input logic [31:0] mask, input logic [5:0] from);
    logic [5:0] r;
    r = diag_pkg::NONE_IDX;
    for (int i = 31; i >= 0; i--) begin
      if (mask[i] && (6'(i) >= from)) begin
        r = 6'(i);
      end
    end
    return r;
  endfunction : next_set

  // Configuration report digit at a position.
  function automatic logic [4:0] cfg_digit(input diag_pkg::cfg_report_t c, input logic [2:0] p);
    logic [3:0] d;
    case (p)
      3'h0: d = c.supply;
      3'h1: d = c.sensors;
      3'h2: d = c.modulators;
      3'h3: d = c.layout;
      3'h4: d = c.traction;
      default: d = c.retarder;
    endcase
    return {1'b0, d};
  endfunction : cfg_digit

  state_t state;
  logic switch_q;
  logic [31:0] tmr;
  logic [4:0] presses;
  logic reconfig_armed;
  diag_pkg::fault_t act [ACT_DEPTH];
  diag_pkg::fault_t hist [HIST_DEPTH];
  logic [HW-1:0] hist_wr;
  logic [ACT_DEPTH-1:0] clr_mask;
  logic [ACT_DEPTH-1:0] hold_mask;
  logic cfg_pending;
  diag_pkg::rep_t rep;
  logic [5:0] idx;
  logic [2:0] pos;
  logic blink_done;

  logic rise, released, press_ok, stuck, dispatch, closed;
  logic [ACT_DEPTH-1:0] act_mask, wss_mask, set_mask, ins_hot, drain_hot;
  logic [31:0] hist_mask, cur_mask;
  logic [5:0] free_idx, drain_idx, first_idx, after_idx;
  logic dup, insert, drain;
  logic [4:0] digit;
  logic last_in_msg, last_msg;
  diag_pkg::tail_t tail;
  diag_pkg::fault_t cur;
  logic next_test_mode;

  // Switch events and press timing.
  always_comb begin
    rise = switch_in && !switch_q;
    released = (state == S_PRESS) && !switch_in;
    press_ok = released && (tmr + 32'h0000_0001 >= PRESS_MIN_CYC) && !vehicle_moving_in; // [R17]
    stuck = (state == S_PRESS) && switch_in && (tmr == PRESS_MAX_CYC - 32'h0000_0001); // [R17]
    closed = tmr >= GAP_MAX_CYC; // [R18]
    dispatch = (state == S_GAP) && (tmr == RESPONSE_PAUSE_CYC - 32'h0000_0001) && !vehicle_moving_in; // [R19]
  end

  // Store occupancy and clear requests.
  always_comb begin
    dup = 1'b0;
    hist_mask = 32'h0000_0000;
    for (int i = 0; i < ACT_DEPTH; i++) begin
      act_mask[i] = act[i].valid;
      wss_mask[i] = act[i].wss;
      if (act[i].valid && (act[i].first == new_fault_in.first) && (act[i].second == new_fault_in.second)) begin
        dup = 1'b1;
      end
    end
    for (int i = 0; i < HIST_DEPTH; i++) begin
      hist_mask[i] = hist[i].valid;
    end
    free_idx = next_set(32'({~act_mask}), 6'h00);
    insert = new_fault_in.valid && !dup && (free_idx != diag_pkg::NONE_IDX);
    ins_hot = insert ? ACT_DEPTH'(1) << free_idx[AW-1:0] : '0;
    set_mask = '0;
    if ((dispatch && (presses == diag_pkg::PRESSES_CLEAR)) || tool_clear_in) begin
      set_mask = act_mask; // [R6] [R9]
    end
    if (ignition_on_in) begin
      set_mask = set_mask | (act_mask & ~wss_mask); // [R4]
    end
    if (wheel_speed_valid_in) begin
      set_mask = set_mask | (act_mask & hold_mask); // [R5]
    end
    drain_idx = next_set(32'(clr_mask & act_mask), 6'h00);
    drain = drain_idx != diag_pkg::NONE_IDX;
    drain_hot = drain ? ACT_DEPTH'(1) << drain_idx[AW-1:0] : '0;
  end

  // Digit due on the lamp.
  always_comb begin
    cur_mask = (rep == diag_pkg::REP_ACTIVE) ? 32'(act_mask) : hist_mask;
    first_idx = next_set(cur_mask, 6'h00);
    after_idx = next_set(cur_mask, idx + 6'h01);
    cur = '{1'b1, 1'b0, diag_pkg::NO_FAULT_CODE, diag_pkg::NO_FAULT_CODE};
    if (idx != diag_pkg::NONE_IDX) begin
      cur = (rep == diag_pkg::REP_ACTIVE) ? act[idx[AW-1:0]] : hist[idx[HW-1:0]];
    end
    digit = 5'h00;
    last_in_msg = 1'b1;
    last_msg = 1'b1;
    unique case (rep)
      diag_pkg::REP_ACTIVE, diag_pkg::REP_INACTIVE: begin
        digit = (pos == 3'h0) ? cur.first : cur.second; // [R3] [R8]
        last_in_msg = pos == 3'h1;
        last_msg = (idx == diag_pkg::NONE_IDX) || (after_idx == diag_pkg::NONE_IDX);
      end
      diag_pkg::REP_CONFIG: begin
        digit = cfg_digit(CFG_REPORT, pos); // [R12] [R13] [R14] [R15] [R16]
        last_in_msg = pos == 3'h5;
      end
      diag_pkg::REP_CONFIRM: begin
        digit = 5'h00;
      end
    endcase
    tail = last_in_msg ? (last_msg ? diag_pkg::TAIL_END : diag_pkg::TAIL_MSG) : diag_pkg::TAIL_DIGIT;
  end

  // Sequence state: press, gap, and playback.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state <= S_IDLE;
      switch_q <= 1'b0;
    end else begin
      switch_q <= switch_in;
      if (vehicle_moving_in && (state != S_STUCK)) begin
        state <= S_IDLE;
      end else if (ignition_on_in) begin
        state <= S_IDLE; // [R2]
      end else begin
        unique case (state)
          S_IDLE: state <= rise ? S_PRESS : S_IDLE;
          S_PRESS: state <= stuck ? S_STUCK : (released ? S_GAP : S_PRESS);
          S_STUCK: state <= switch_in ? S_STUCK : S_IDLE;
          S_GAP: begin
            if (rise && !closed) begin
              state <= S_PRESS;
            end else if (dispatch) begin
              // Unlisted counts select nothing.
              unique case (presses)
                diag_pkg::PRESSES_ACTIVE, diag_pkg::PRESSES_INACTIVE, diag_pkg::PRESSES_CONFIG,
                diag_pkg::PRESSES_CLEAR, diag_pkg::PRESSES_TEST: state <= S_DIGIT; // [R1] [R11]
                default: state <= S_IDLE; // [R21]
              endcase
            end
          end
          S_DIGIT: state <= S_WAIT;
          S_WAIT: begin
            if (blink_done) begin
              state <= (tail == diag_pkg::TAIL_END) ? S_IDLE : S_DIGIT;
            end
          end
          default: state <= S_IDLE;
        endcase
      end
    end
  end

  // Press, gap and pause timer.
  always_ff @(posedge clk_in) begin
    if (reset_in || (state == S_IDLE) || released) begin
      tmr <= 32'h0000_0000;
    end else if (tmr != 32'hFFFF_FFFF) begin
      tmr <= tmr + 32'h0000_0001;
    end
  end

  // Valid presses in the current sequence.
  always_ff @(posedge clk_in) begin
    if (reset_in || (state == S_IDLE)) begin
      presses <= 5'h00;
    end else if (press_ok && (presses != 5'h1F)) begin
      presses <= presses + 5'h01; // [R17]
    end
  end

  // Report and position.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rep <= diag_pkg::REP_CONFIRM;
      idx <= diag_pkg::NONE_IDX;
      pos <= 3'h0;
    end else if (dispatch) begin
      pos <= 3'h0;
      unique case (presses)
        diag_pkg::PRESSES_ACTIVE: begin
          rep <= diag_pkg::REP_ACTIVE; // [R1]
          idx <= next_set(32'(act_mask), 6'h00);
        end
        diag_pkg::PRESSES_INACTIVE: begin
          rep <= diag_pkg::REP_INACTIVE; // [R8]
          idx <= next_set(hist_mask, 6'h00);
        end
        diag_pkg::PRESSES_CONFIG: rep <= diag_pkg::REP_CONFIG; // [R12]
        default: rep <= diag_pkg::REP_CONFIRM;
      endcase
    end else if ((state == S_WAIT) && blink_done) begin
      if (last_in_msg) begin
        pos <= 3'h0;
        idx <= after_idx; // [R3]
      end else begin
        pos <= pos + 3'h1;
      end
    end
  end

  // Active fault store.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      for (int i = 0; i < ACT_DEPTH; i++) begin
        act[i] <= '0;
      end
    end else begin
      if (drain) begin
        act[drain_idx[AW-1:0]].valid <= 1'b0;
      end
      if (insert) begin
        act[free_idx[AW-1:0]] <= '{1'b1, new_fault_in.wss, new_fault_in.first, new_fault_in.second};
      end
    end
  end

  // Pending clears; a new request wins over a drain.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      clr_mask <= '0;
    end else begin
      clr_mask <= (clr_mask & ~drain_hot & ~ins_hot) | set_mask;
    end
  end

  // Sensor codes at power-up wait for wheel speed.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      hold_mask <= '0;
    end else begin
      hold_mask <= (hold_mask & ~drain_hot & ~ins_hot) | (ignition_on_in ? act_mask & wss_mask : '0); // [R5]
    end
  end

  // History store: cleared codes before configuration events.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      hist_wr <= '0;
      for (int i = 0; i < HIST_DEPTH; i++) begin
        hist[i] <= '0;
      end
    end else if (drain) begin
      hist[hist_wr] <= act[drain_idx[AW-1:0]]; // [R7]
      hist_wr <= hist_wr + HW'(1);
    end else if (cfg_pending) begin
      hist[hist_wr] <= '{1'b1, 1'b0, diag_pkg::CFG_EVENT_FIRST, diag_pkg::CFG_EVENT_SECOND}; // [R7]
      hist_wr <= hist_wr + HW'(1);
    end
  end

  // Configuration event to log; a new change wins.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cfg_pending <= 1'b0;
    end else begin
      cfg_pending <= config_change_in || (cfg_pending && drain);
    end
  end

  // Switch fault stays until power returns; a new fault wins.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      switch_fault_out <= 1'b0;
    end else begin
      switch_fault_out <= stuck || (switch_fault_out && !ignition_on_in); // [R17]
    end
  end

  // Switch held at power-up arms reconfiguration.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      reconfig_armed <= 1'b0;
      reconfig_mode_out <= 1'b0;
    end else if (ignition_on_in) begin
      reconfig_armed <= switch_in; // [R2]
      reconfig_mode_out <= 1'b0;
    end else if (dispatch) begin
      reconfig_armed <= 1'b0;
      if (reconfig_armed && (presses == diag_pkg::PRESSES_RECONFIG)) begin
        reconfig_mode_out <= 1'b1; // [R2]
      end
    end
  end

  // Test mode survives power cycles; tool clear wins.
  always_comb begin
    next_test_mode = test_mode_out;
    if (tool_test_set_in || (dispatch && (presses == diag_pkg::PRESSES_TEST))) begin
      next_test_mode = 1'b1;
    end
    if (tool_test_clear_in) begin
      next_test_mode = 1'b0; // [R10]
    end
  end

  // Test mode disables traction control.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      test_mode_out <= 1'b0;
      traction_control_enable_out <= 1'b1;
    end else begin
      test_mode_out <= next_test_mode; // [R10]
      traction_control_enable_out <= !next_test_mode; // [R10]
    end
  end

  // Lamp sequencer.
  blink_player #(
    .ON_CYC(BLINK_ON_CYC),
    .OFF_CYC(BLINK_OFF_CYC),
    .DIGIT_GAP_CYC(DIGIT_GAP_CYC),
    .MSG_GAP_CYC(MSG_GAP_CYC),
    .END_CYC(END_ON_CYC)
  ) u_blink (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .start_in(state == S_DIGIT),
    .abort_in(vehicle_moving_in),
    .count_in(digit),
    .tail_in(tail),
    .lamp_out(lamp_out),
    .done_out(blink_done)
  );
endmodule : blink_code_diag_mode_selector

/* File: blink_code_diag_mode_selector_tb.sv */
`timescale 1ns/1ns
module blink_code_diag_mode_selector_tb;
  logic clk_in, reset_in, ignition, tool_set, tool_clr, go, level, lamp_q;
  logic sw, busy, lamp, sw_fault, test_mode, traction, reconfig, moving, speed, wipe, cfg_chg;
  logic [3:0] presses;
  logic [7:0] hold;
  diag_pkg::fault_t fault;
  int failures, checks_done, rises, base, cycles;
  // Shortened timing.
  blink_code_diag_mode_selector #(.PRESS_MIN_CYC(32'h0000_0004), .PRESS_MAX_CYC(32'h0000_0032),
    .GAP_MAX_CYC(32'h0000_0014), .RESPONSE_PAUSE_CYC(32'h0000_001E), .BLINK_ON_CYC(32'h0000_0003),
    .BLINK_OFF_CYC(32'h0000_0003), .DIGIT_GAP_CYC(32'h0000_0006), .MSG_GAP_CYC(32'h0000_0008),
    .END_ON_CYC(32'h0000_000A)) dut (.clk_in, .reset_in, .switch_in(sw), .ignition_on_in(ignition),
    .vehicle_moving_in(moving), .wheel_speed_valid_in(speed), .new_fault_in(fault), .config_change_in(cfg_chg),
    .tool_clear_in(wipe), .tool_test_set_in(tool_set), .tool_test_clear_in(tool_clr), .lamp_out(lamp),
    .switch_fault_out(sw_fault), .test_mode_out(test_mode), .traction_control_enable_out(traction),
    .reconfig_mode_out(reconfig));
  tech_panel panel (.clk_in, .go_in(go), .level_in(level), .presses_in(presses), .hold_in(hold),
    .switch_out(sw), .busy_out(busy));
  // Clock, rise counter, hang guard.
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    lamp_q <= lamp;
    if (lamp && !lamp_q) rises <= rises + 1;
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      failures++;
      wrap_up();
    end
  end
  // Compares and counts.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t: got %0d expected %0d", $time, seen, exp);
    end
  endtask : check
  // Presses n times and counts lamp rises.
  task automatic run(input logic [3:0] n, input logic [7:0] h, input logic [7:0] exp);
    presses <= n;
    hold <= h;
    go <= 1'b1;
    @(posedge clk_in);
    go <= 1'b0;
    repeat (2) @(posedge clk_in);
    while (busy) @(posedge clk_in);
    base = rises;
    repeat (300) @(posedge clk_in);
    check(8'(rises - base), exp);
  endtask : run
  task automatic ign_pulse();
    ignition <= 1'b1;
    @(posedge clk_in);
    ignition <= 1'b0;
    @(posedge clk_in);
  endtask : ign_pulse
  task automatic t_reports();
    fault <= '{valid: 1'b1, wss: 1'b0, first: 5'h03, second: 5'h02};
    @(posedge clk_in);
    fault <= '0;
    run(4'h1, 8'h06, 8'h06);
    run(4'h4, 8'h06, 8'h16);
    run(4'h3, 8'h06, 8'h01);
    run(4'h1, 8'h06, 8'h03);
    run(4'h2, 8'h06, 8'h06);
    fault <= '{valid: 1'b1, wss: 1'b1, first: 5'h02, second: 5'h01};
    @(posedge clk_in);
    fault <= '0;
    ign_pulse();
    run(4'h1, 8'h06, 8'h04);
    wipe <= 1'b1;
    @(posedge clk_in);
    wipe <= 1'b0;
    run(4'h1, 8'h06, 8'h03);
    $display("reports done");
  endtask : t_reports
  task automatic t_test();
    run(4'h5, 8'h06, 8'h01);
    check(test_mode, 8'h01);
    check(traction, 8'h00);
    ign_pulse();
    check(test_mode, 8'h01);
    tool_clr <= 1'b1;
    @(posedge clk_in);
    tool_clr <= 1'b0;
    repeat (3) @(posedge clk_in);
    check(traction, 8'h01);
    tool_set <= 1'b1;
    @(posedge clk_in);
    tool_set <= 1'b0;
    repeat (2) @(posedge clk_in);
    check(test_mode, 8'h01);
    $display("test done");
  endtask : t_test
  task automatic t_odd();
    run(4'h6, 8'h06, 8'h00);
    run(4'h7, 8'h06, 8'h00);
    check(reconfig, 8'h00);
    run(4'h1, 8'h02, 8'h00);
    run(4'h1, 8'h3C, 8'h00);
    check(sw_fault, 8'h01);
    $display("odd done");
  endtask : t_odd
  task automatic t_reconfig();
    level <= 1'b1;
    repeat (2) @(posedge clk_in);
    ign_pulse();
    check(sw_fault, 8'h00);
    level <= 1'b0;
    repeat (10) @(posedge clk_in);
    run(4'h7, 8'h06, 8'h00);
    check(reconfig, 8'h01);
    $display("reconfig done");
  endtask : t_reconfig
  task automatic wrap_up();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  // Reset, then the scenarios.
  initial begin
    {ignition, tool_set, tool_clr, go, level, lamp_q, moving, speed, wipe, cfg_chg} = '0;
    {failures, checks_done, rises, base, cycles} = '0;
    reset_in = 1'b1;
    fault = '0;
    presses = '0;
    hold = '0;
    repeat (3) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    t_reports();
    t_test();
    t_odd();
    t_reconfig();
    wrap_up();
  end
endmodule : blink_code_diag_mode_selector_tb

/* File: blink_player.sv */
`timescale 1ns/1ns
module blink_player #(
  parameter logic [31:0] ON_CYC = diag_pkg::BLINK_ON_CYC,
  parameter logic [31:0] OFF_CYC = diag_pkg::BLINK_OFF_CYC,
  parameter logic [31:0] DIGIT_GAP_CYC = diag_pkg::DIGIT_GAP_CYC,
  parameter logic [31:0] MSG_GAP_CYC = diag_pkg::MSG_GAP_CYC,
  parameter logic [31:0] END_CYC = diag_pkg::END_ON_CYC
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic reset_in,
  // Digit request.
  input wire logic start_in,
  input wire logic abort_in,
  input wire logic [4:0] count_in,
  input wire diag_pkg::tail_t tail_in,
  // Lamp and completion.
  output logic lamp_out,
  output logic done_out
);
  typedef enum logic [2:0] {
    B_IDLE = 3'b000,
    B_ON = 3'b001,
    B_OFF = 3'b010,
    B_TAIL = 3'b011,
    B_HOLD = 3'b100
  } bstate_t;

  bstate_t state;
  logic [31:0] t;
  logic [4:0] left;
  diag_pkg::tail_t tail;
  logic [31:0] tail_len;

  // Digit gap inside a message, message gap otherwise.
  always_comb begin
    tail_len = (tail == diag_pkg::TAIL_DIGIT) ? DIGIT_GAP_CYC : MSG_GAP_CYC; // [R20]
  end

  // Blinks of one digit, its pause and the closing hold.
  always_ff @(posedge clk_in) begin
    if (reset_in || abort_in) begin
      state <= B_IDLE;
      t <= 32'h0000_0000;
      left <= 5'h00;
      tail <= diag_pkg::TAIL_DIGIT;
    end else begin
      unique case (state)
        B_IDLE: begin
          if (start_in) begin
            t <= 32'h0000_0000;
            left <= count_in;
            tail <= tail_in;
            state <= (count_in == 5'h00) ? B_TAIL : B_ON;
          end
        end
        B_ON: begin
          if (t == ON_CYC - 32'h0000_0001) begin // [R20]
            t <= 32'h0000_0000;
            left <= left - 5'h01;
            state <= (left == 5'h01) ? B_TAIL : B_OFF;
          end else begin
            t <= t + 32'h0000_0001;
          end
        end
        B_OFF: begin
          if (t == OFF_CYC - 32'h0000_0001) begin // [R20]
            t <= 32'h0000_0000;
            state <= B_ON;
          end else begin
            t <= t + 32'h0000_0001;
          end
        end
        B_TAIL: begin
          if (t == tail_len - 32'h0000_0001) begin
            t <= 32'h0000_0000;
            state <= (tail == diag_pkg::TAIL_END) ? B_HOLD : B_IDLE;
          end else begin
            t <= t + 32'h0000_0001;
          end
        end
        B_HOLD: begin
          if (t == END_CYC - 32'h0000_0001) begin // [R20]
            t <= 32'h0000_0000;
            state <= B_IDLE;
          end else begin
            t <= t + 32'h0000_0001;
          end
        end
        default: begin
          state <= B_IDLE;
        end
      endcase
    end
  end

  // Lamp lit in each blink and the closing hold.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      lamp_out <= 1'b0;
    end else begin
      lamp_out <= (state == B_ON) || (state == B_HOLD);
    end
  end

  // Pulse when the digit and its tail are over.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      done_out <= 1'b0;
    end else begin
      done_out <= !abort_in && (((state == B_TAIL) && (tail != diag_pkg::TAIL_END) && (t == tail_len - 32'h0000_0001)) ||
                                ((state == B_HOLD) && (t == END_CYC - 32'h0000_0001)));
    end
  end
endmodule : blink_player

/* File: diag_checker_properties.sv */
`timescale 1ns/1ns
module diag_checker (
  // Watched ports.
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic switch_in,
  input wire logic ignition_on_in,
  input wire logic tool_test_set_in,
  input wire logic tool_test_clear_in,
  input wire logic lamp_out,
  input wire logic switch_fault_out,
  input wire logic test_mode_out,
  input wire logic traction_control_enable_out,
  input wire logic reconfig_mode_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // Test mode and traction control.
  test_set_a: assert property (tool_test_set_in && !tool_test_clear_in |-> ##[1:2] test_mode_out)
    else $error("test mode not set");
  test_clear_a: assert property (tool_test_clear_in |-> ##[1:2] !test_mode_out)
    else $error("test mode not cleared");
  test_hold_a: assert property (test_mode_out && !tool_test_clear_in |=> test_mode_out)
    else $error("test mode lost");
  traction_off_a: assert property ($rose(test_mode_out) |-> ##[0:1] !traction_control_enable_out)
    else $error("traction control left on");
  // Switch fault cause and hold; reconfiguration hold and clear.
  fault_cause_a: assert property ($rose(switch_fault_out) |-> $past(switch_in))
    else $error("fault without press");
  fault_hold_a: assert property (switch_fault_out && !ignition_on_in |=> switch_fault_out)
    else $error("switch fault dropped");
  recfg_hold_a: assert property (reconfig_mode_out && !ignition_on_in |=> reconfig_mode_out)
    else $error("reconfig dropped");
  recfg_clear_a: assert property (ignition_on_in |-> ##[1:2] !reconfig_mode_out)
    else $error("reconfig kept");
  // Minimum lamp phases.
  lamp_on_a: assert property ($rose(lamp_out) |-> lamp_out [*3])
    else $error("lamp on too short");
  lamp_off_a: assert property ($fell(lamp_out) |-> !lamp_out [*3])
    else $error("lamp off too short");
endmodule : diag_checker
bind blink_code_diag_mode_selector diag_checker chk (.clk_in, .reset_in, .switch_in, .ignition_on_in,
  .tool_test_set_in, .tool_test_clear_in, .lamp_out, .switch_fault_out, .test_mode_out,
  .traction_control_enable_out, .reconfig_mode_out);

/* File: diag_pkg.sv */
package diag_pkg;
  // Clock rate in kHz; milliseconds times this give cycles.
  localparam int unsigned CLK_KHZ = 125000;
  // Timing in milliseconds.
  localparam int unsigned PRESS_MIN_MS = 100;
  localparam int unsigned PRESS_MAX_MS = 5000;
  localparam int unsigned GAP_MAX_MS = 2000;
  localparam int unsigned RESPONSE_PAUSE_MS = 3500;
  localparam int unsigned BLINK_ON_MS = 500;
  localparam int unsigned BLINK_OFF_MS = 500;
  localparam int unsigned DIGIT_GAP_MS = 1500;
  localparam int unsigned MSG_GAP_MS = 2500;
  localparam int unsigned END_ON_MS = 5000;
  // Derived cycle counts.
  localparam logic [31:0] PRESS_MIN_CYC = 32'(PRESS_MIN_MS * CLK_KHZ);
  localparam logic [31:0] PRESS_MAX_CYC = 32'(PRESS_MAX_MS * CLK_KHZ);
  localparam logic [31:0] GAP_MAX_CYC = 32'(GAP_MAX_MS * CLK_KHZ);
  localparam logic [31:0] RESPONSE_PAUSE_CYC = 32'(RESPONSE_PAUSE_MS * CLK_KHZ);
  localparam logic [31:0] BLINK_ON_CYC = 32'(BLINK_ON_MS * CLK_KHZ);
  localparam logic [31:0] BLINK_OFF_CYC = 32'(BLINK_OFF_MS * CLK_KHZ);
  localparam logic [31:0] DIGIT_GAP_CYC = 32'(DIGIT_GAP_MS * CLK_KHZ);
  localparam logic [31:0] MSG_GAP_CYC = 32'(MSG_GAP_MS * CLK_KHZ);
  localparam logic [31:0] END_ON_CYC = 32'(END_ON_MS * CLK_KHZ);
  // Mode press counts.
  localparam logic [4:0] PRESSES_ACTIVE = 5'h01;
  localparam logic [4:0] PRESSES_INACTIVE = 5'h02;
  localparam logic [4:0] PRESSES_CLEAR = 5'h03;
  localparam logic [4:0] PRESSES_CONFIG = 5'h04;
  localparam logic [4:0] PRESSES_TEST = 5'h05;
  localparam logic [4:0] PRESSES_RECONFIG = 5'h07;
  // Code pair for an empty store.
  localparam logic [4:0] NO_FAULT_CODE = 5'h01;
  // Configuration change history entry; values arbitrary.
  localparam logic [4:0] CFG_EVENT_FIRST = 5'h1F;
  localparam logic [4:0] CFG_EVENT_SECOND = 5'h01;
  // No entry found.
  localparam logic [5:0] NONE_IDX = 6'h20;
  // Configuration report encodings.
  localparam logic [3:0] SUPPLY_12V = 4'h1;
  localparam logic [3:0] SUPPLY_24V = 4'h2;
  localparam logic [3:0] SENSORS_4 = 4'h4;
  localparam logic [3:0] SENSORS_6 = 4'h6;
  localparam logic [3:0] MODULATORS_4 = 4'h4;
  localparam logic [3:0] MODULATORS_5 = 4'h5;
  localparam logic [3:0] MODULATORS_6 = 4'h6;
  localparam logic [3:0] LAYOUT_SAME = 4'h1;
  localparam logic [3:0] LAYOUT_6S4M = 4'h2;
  localparam logic [3:0] LAYOUT_6S5M = 4'h3;
  localparam logic [3:0] TRACTION_NONE = 4'h2;
  localparam logic [3:0] TRACTION_ENGINE = 4'h3;
  localparam logic [3:0] TRACTION_BRAKE = 4'h4;
  localparam logic [3:0] TRACTION_FULL = 4'h5;
  localparam logic [3:0] RETARDER_NONE = 4'h1;
  localparam logic [3:0] RETARDER_NETWORK = 4'h2;
  localparam logic [3:0] RETARDER_RELAY = 4'h3;
  localparam logic [3:0] RETARDER_BOTH = 4'h4;

  // What follows the last blink of a digit.
  typedef enum logic [1:0] {
    TAIL_DIGIT = 2'b00,
    TAIL_MSG = 2'b01,
    TAIL_END = 2'b10
  } tail_t;

  // What the lamp is reporting.
  typedef enum logic [1:0] {
    REP_ACTIVE = 2'b00,
    REP_INACTIVE = 2'b01,
    REP_CONFIG = 2'b10,
    REP_CONFIRM = 2'b11
  } rep_t;

  // One trouble code: two digits and a wheel speed sensor flag.
  typedef struct packed {
    logic valid;
    logic wss;
    logic [4:0] first;
    logic [4:0] second;
  } fault_t;

  // Configuration report digits in order.
  typedef struct packed {
    logic [3:0] supply;
    logic [3:0] sensors;
    logic [3:0] modulators;
    logic [3:0] layout;
    logic [3:0] traction;
    logic [3:0] retarder;
  } cfg_report_t;

  localparam cfg_report_t FITTED_CFG = '{SUPPLY_24V, SENSORS_6, MODULATORS_6, LAYOUT_SAME, TRACTION_FULL,
                                         RETARDER_NONE};
endpackage : diag_pkg

/* File: tech_panel.sv */
`timescale 1ns/1ns
module tech_panel (
  // Clock and request.
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic level_in,
  input wire logic [3:0] presses_in,
  input wire logic [7:0] hold_in,
  // Switch contact.
  output logic switch_out,
  output logic busy_out
);
  logic press;
  // Level holds the switch down over power-up.
  assign switch_out = press | level_in;
  // Presses the switch n times.
  initial begin
    press = 1'b0;
    busy_out = 1'b0;
    forever begin
      @(posedge clk_in);
      if (go_in && !busy_out) begin
        busy_out <= 1'b1;
        repeat (presses_in) begin
          press <= 1'b1;
          repeat (hold_in) @(posedge clk_in);
          press <= 1'b0;
          repeat (6) @(posedge clk_in); // Gap inside the limit
        end
        busy_out <= 1'b0;
      end
    end
  end
endmodule : tech_panel
